// ===== shared/clb_if.sv
// Signals between the register block, decoder and mode selector
interface clb_if;
  logic [1:0]         vfloor_code;
  logic [2:0]         imin_code;
  clb_pkg::clb_milli_t floor_mv;
  clb_pkg::clb_milli_t imin_ma;
  clb_pkg::clb_milli_t current_limit_setting_ma;
  logic               trip;

  modport ctl (output vfloor_code, output imin_code, output current_limit_setting_ma,
               input floor_mv, input imin_ma, input trip);
  modport dec (input vfloor_code, input imin_code,
               output floor_mv, output imin_ma);
  modport sel (input imin_ma, input current_limit_setting_ma, output trip);
endinterface

// ===== shared/clb_map.svh
// Register offsets, field positions, reset values and decode constants
//
// Behaviour
// - Applied register holds thresholds; software read-only
// - Load applied register when emulation completes
// - Applied register contents lost in Sleep
// - Custom register keeps contents through Sleep
// - Custom thresholds for listed handshake outcomes
// - Bus voltage floor code decodes 1.5-2.25 V
// - Bus voltage floor checked in both modes
// - Minimum current code decodes 100-1800 mA
// - Custom minimum current resets to 100 mA
// - Trip when threshold at/below limit or >1.5A; with the applied set, trip follows emu_trip_sel instead
// - Read-only 8-bit part identity register
// - Read-only 8-bit maker identity register
// - Read-only 8-bit silicon revision register
`ifndef CLB_MAP_SVH
`define CLB_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CLB_ADDR_APPLIED 8'h50
`define CLB_ADDR_CUSTOM  8'h51
`define CLB_ADDR_PART    8'hFD
`define CLB_ADDR_MAKER   8'hFE
`define CLB_ADDR_REV     8'hFF

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CLB_VFLOOR_HI    7
`define CLB_VFLOOR_LO    6
`define CLB_ZERO_BIT     5
`define CLB_IMIN_HI      4
`define CLB_IMIN_LO      2
`define CLB_RSVD_HI      1
`define CLB_RSVD_LO      0
`define CLB_RESET_VAL    8'h82

// ------------------------------------------------------------
// Decoded thresholds, millivolts and milliamps
// ------------------------------------------------------------
`define CLB_MV_1500      13'h05DC
`define CLB_MV_1750      13'h06D6
`define CLB_MV_2000      13'h07D0
`define CLB_MV_2250      13'h08CA
`define CLB_MA_100       13'h0064
`define CLB_MA_500       13'h01F4
`define CLB_MA_900       13'h0384
`define CLB_MA_1200      13'h04B0
`define CLB_MA_1500      13'h05DC
`define CLB_MA_1800      13'h0708
`define CLB_TRIP_ABOVE   13'h05DC

`endif

// ===== shared/clb_pkg.sv
// Types shared by the current limit behaviour block
package clb_pkg;

  // Outcome of the last charger emulation cycle
  typedef enum logic [2:0] {
    CLB_OUT_NONE,
    CLB_OUT_LEGACY2,
    CLB_OUT_LEGACY_OTHER,
    CLB_OUT_CUSTOM,
    CLB_OUT_NO_HANDSHAKE,
    CLB_OUT_OTHER
  } clb_outcome_t;

  typedef logic [12:0] clb_milli_t;

endpackage

// ===== test/clb_top_asserts.sv
// Port checks for the current limit behaviour block
`include "clb_map.svh"

module clb_top_asserts #(
  parameter logic [7:0] PART_ID  = 8'hA5, // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] REV_ID   = 8'h01  // Arbitrary value
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        sleep_active,
  input wire logic        emu_done,
  input wire logic [12:0] current_limit_setting,
  input wire logic [12:0] bus_voltage_mv,
  input wire logic        custom_in_use,
  input wire logic        trip_limiting,
  input wire logic        constant_current_limiting,
  input wire logic [12:0] bus_voltage_floor,
  input wire logic [12:0] min_current_threshold,
  input wire logic        bus_under_floor
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_cc_inverse: assert property (
    constant_current_limiting != trip_limiting) else $error("modes clash");
  a_part_read: assert property (
    reg_rd && reg_addr == `CLB_ADDR_PART |=> reg_rdata == PART_ID)
    else $error("part code wrong");
  a_maker_read: assert property (
    reg_rd && reg_addr == `CLB_ADDR_MAKER |=> reg_rdata == MAKER_ID)
    else $error("maker code wrong");
  a_rev_read: assert property (
    reg_rd && reg_addr == `CLB_ADDR_REV |=> reg_rdata == REV_ID)
    else $error("revision wrong");
  a_applied_fixed: assert property (
    reg_rd && reg_addr == `CLB_ADDR_APPLIED |=>
    reg_rdata[5] == 1'b0 && reg_rdata[1:0] == 2'b10)
    else $error("applied fixed bits wrong");
  a_sleep_applied: assert property (
    sleep_active ##1 sleep_active && reg_rd
    && reg_addr == `CLB_ADDR_APPLIED |=> reg_rdata == `CLB_RESET_VAL)
    else $error("applied kept in sleep");
  a_floor_codes: assert property (
    bus_voltage_floor inside {13'h05DC, 13'h06D6, 13'h07D0, 13'h08CA})
    else $error("floor value off table");
  a_imin_codes: assert property (
    min_current_threshold inside {13'h0064, 13'h01F4, 13'h0384,
    13'h04B0, 13'h05DC, 13'h0708}) else $error("threshold off table");
  a_under_floor: assert property (
    ($stable(bus_voltage_mv) && $stable(bus_voltage_floor)) [*2] |->
    bus_under_floor == (bus_voltage_mv < bus_voltage_floor))
    else $error("floor compare wrong");
  a_custom_trip: assert property (
    ($stable(current_limit_setting) && custom_in_use) [*2] |->
    trip_limiting == (min_current_threshold <= current_limit_setting
    || current_limit_setting > 13'h05DC)) else $error("custom mode wrong");

  c_custom: cover property (emu_done ##2 custom_in_use);
  c_sleep: cover property (sleep_active ##1 !sleep_active);
  c_wr_custom: cover property (reg_wr && reg_addr == `CLB_ADDR_CUSTOM);
endmodule

bind clb_top clb_top_asserts #(.PART_ID(PART_ID), .MAKER_ID(MAKER_ID),
  .REV_ID(REV_ID)) i_clb_top_asserts (.*);

// ===== test/tb_clb_top.sv
// Self-checking bench for the current limit behaviour registers
module tb_clb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PART_ID  = 8'h6B; // Arbitrary value
  localparam logic [7:0] MAKER_ID = 8'h2D; // Arbitrary value
  localparam logic [7:0] REV_ID   = 8'h03; // Arbitrary value
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sleep_active = 1'b0;
  logic        emu_done = 1'b0;
  logic [2:0]  emu_outcome = 3'h0;
  logic        emu_trip_sel = 1'b0;
  logic [1:0]  emu_bus_voltage_floor = 2'h0;
  logic [2:0]  emu_min_current_threshold = 3'h0;
  logic [12:0] current_limit_setting = 13'h03E8;
  logic [12:0] bus_voltage_mv = 13'h1388;
  logic        custom_in_use;
  logic        trip_limiting;
  logic        constant_current_limiting;
  logic [12:0] bus_voltage_floor;
  logic [12:0] min_current_threshold;
  logic        bus_under_floor;
  logic [12:0] mv_t [4] = '{13'h05DC, 13'h06D6, 13'h07D0, 13'h08CA};
  logic [12:0] ma_t [8] = '{13'h0064, 13'h01F4, 13'h0384, 13'h04B0,
                            13'h05DC, 13'h0708, 13'h0708, 13'h0708};
  logic [7:0]  ro_a [4] = '{8'h50, 8'hFD, 8'hFE, 8'hFF};
  logic [7:0]  ro_e [4] = '{8'h82, PART_ID, MAKER_ID, REV_ID};
  logic [7:0]  exp_q [$];
  logic        rd_pend = 1'b0;
  logic [7:0]  cust = 8'h82;
  int          err_count = 0;
  int          checked = 0;

  clb_top #(.PART_ID(PART_ID), .MAKER_ID(MAKER_ID), .REV_ID(REV_ID))
    i_clb_top (.*);

  // Clock at 20 MHz
  always #25 sys_clk = ~sys_clk;

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_pend) begin
      chk(exp_q.size() > 0 && reg_rdata === exp_q.pop_front(), "read");
    end
    rd_pend <= reg_rd;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Emulation finishes with a given outcome and random fields
  task automatic emu(input logic [2:0] oc, input logic ts);
    logic [1:0]  vf;
    logic [2:0]  im;
    logic        cu;
    logic [12:0] th;
    logic [12:0] fl;
    vf = 2'($urandom);
    im = 3'($urandom);
    @(posedge sys_clk);
    emu_done <= 1'b1;
    emu_outcome <= oc;
    emu_trip_sel <= ts;
    emu_bus_voltage_floor <= vf;
    emu_min_current_threshold <= im;
    current_limit_setting <= 13'($urandom_range(13'h07D0, 13'h0032));
    bus_voltage_mv <= 13'($urandom_range(13'h0960, 13'h0578));
    @(posedge sys_clk);
    emu_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    cu = oc inside {3'h2, 3'h3, 3'h4};
    th = cu ? ma_t[cust[4:2]] : ma_t[im];
    fl = cu ? mv_t[cust[7:6]] : mv_t[vf];
    chk(custom_in_use === cu, "custom select");
    chk(min_current_threshold === th, "threshold");
    chk(bus_voltage_floor === fl, "floor");
    chk(bus_under_floor === (bus_voltage_mv < fl), "under");
    chk(trip_limiting === (cu ? (th <= current_limit_setting ||
      current_limit_setting > 13'h05DC) : ts), "mode");
    rd(8'h50, {vf, 1'b0, im, 2'b10});
  endtask

  // Main sequence
  initial begin
    void'($urandom(86778));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h51, 8'h82);
    rd(8'h33, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(ro_a[i], ro_e[i]);
      wr(ro_a[i], ~ro_e[i]);
      rd(ro_a[i], ro_e[i]);
    end
    for (int i = 0; i < 16; i++) begin
      cust = 8'($urandom);
      cust[5] = 1'b0;
      cust[1:0] = 2'b10;
      wr(8'h51, cust);
      rd(8'h51, cust);
      emu(3'(i % 8), 1'($urandom));
    end
    emu(3'h3, 1'b0);
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    emu_done <= 1'b1;
    @(posedge sys_clk);
    emu_done <= 1'b0;
    rd(8'h50, 8'h82);
    chk(custom_in_use === 1'b0, "sleep select");
    sleep_active <= 1'b0;
    rd(8'h50, 8'h82);
    rd(8'h51, cust);
    chk(custom_in_use === 1'b0, "sleep outcome");
    repeat (3) @(posedge sys_clk);
    chk(exp_q.size() == 0, "reads lost");
    summarize();
  end

  // Watchdog
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule

// ===== verilog/clb_decode.sv
// Decoder from threshold codes to millivolts and milliamps
`include "clb_map.svh"

module clb_decode (
  clb_if.dec bus
);

  // ----------------------------------------------------------
  // Bus voltage floor decode
  // ----------------------------------------------------------
  always_comb begin
    case (bus.vfloor_code)
      2'h0:    bus.floor_mv = `CLB_MV_1500;
      2'h1:    bus.floor_mv = `CLB_MV_1750;
      2'h2:    bus.floor_mv = `CLB_MV_2000;
      2'h3:    bus.floor_mv = `CLB_MV_2250;
      default: bus.floor_mv = `CLB_MV_2000;
    endcase
  end

  // ----------------------------------------------------------
  // Minimum current decode; unused codes clamp to the top step
  // ----------------------------------------------------------
  always_comb begin
    case (bus.imin_code)
      3'h0:    bus.imin_ma = `CLB_MA_100;
      3'h1:    bus.imin_ma = `CLB_MA_500;
      3'h2:    bus.imin_ma = `CLB_MA_900;
      3'h3:    bus.imin_ma = `CLB_MA_1200;
      3'h4:    bus.imin_ma = `CLB_MA_1500;
      3'h5:    bus.imin_ma = `CLB_MA_1800;
      default: bus.imin_ma = `CLB_MA_1800;
    endcase
  end

endmodule

// ===== verilog/clb_select.sv
// Trip or constant-current choice for the custom thresholds
`include "clb_map.svh"

module clb_select (
  clb_if.sel bus
);

  // Trip when threshold is at or below limit, or limit is high
  always_comb begin
    bus.trip = (bus.imin_ma <= bus.current_limit_setting_ma) ||
               (bus.current_limit_setting_ma > `CLB_TRIP_ABOVE);
  end

endmodule

// ===== verilog/clb_top.sv
// Current limit behaviour registers and threshold selection
//
// Design decision made here: the plain strobed port.
`include "clb_map.svh"

module clb_top #(
  parameter logic [7:0] PART_ID  = 8'hA5, // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] REV_ID   = 8'h01  // Arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        sleep_active,
  input  wire logic        emu_done,
  input  wire logic [2:0]  emu_outcome,
  input  wire logic        emu_trip_sel,
  input  wire logic [1:0]  emu_bus_voltage_floor,
  input  wire logic [2:0]  emu_min_current_threshold,
  input  wire logic [12:0] current_limit_setting,
  input  wire logic [12:0] bus_voltage_mv,
  output logic             custom_in_use,
  output logic             trip_limiting,
  output logic             constant_current_limiting,
  output logic [12:0]      bus_voltage_floor,
  output logic [12:0]      min_current_threshold,
  output logic             bus_under_floor
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [1:0]           applied_bus_voltage_floor_q;
  logic [2:0]           applied_min_current_threshold_q;
  logic [1:0]           applied_rsvd_q;
  logic                 applied_trip_q;
  logic [1:0]           custom_bus_voltage_floor_q;
  logic [2:0]           custom_min_current_threshold_q;
  logic [1:0]           custom_rsvd_q;
  clb_pkg::clb_outcome_t outcome_q;
  logic                 use_custom_d;
  logic [7:0]           applied_reg;
  logic [7:0]           custom_reg;
  logic [7:0]           rdata_d;
  logic                 trip_d;

  // Register reset image, split into its fields below
  localparam logic [7:0] RST_IMAGE = `CLB_RESET_VAL;

  clb_if link ();

  // ----------------------------------------------------------
  // Decoder and mode selector
  // ----------------------------------------------------------
  clb_decode u_decode (
    .bus (link.dec)
  );

  clb_select u_select (
    .bus (link.sel)
  );

  // ----------------------------------------------------------
  // Register images as software sees them
  // ----------------------------------------------------------
  always_comb begin
    applied_reg = 8'h00;
    applied_reg[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO] =
      applied_bus_voltage_floor_q;
    applied_reg[`CLB_IMIN_HI:`CLB_IMIN_LO] =
      applied_min_current_threshold_q;
    applied_reg[`CLB_RSVD_HI:`CLB_RSVD_LO] = applied_rsvd_q;
  end

  always_comb begin
    custom_reg = 8'h00;
    custom_reg[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO] =
      custom_bus_voltage_floor_q;
    custom_reg[`CLB_IMIN_HI:`CLB_IMIN_LO] =
      custom_min_current_threshold_q;
    custom_reg[`CLB_RSVD_HI:`CLB_RSVD_LO] = custom_rsvd_q;
  end

  // ----------------------------------------------------------
  // Applied register: hardware loaded, lost in Sleep
  // ----------------------------------------------------------
  // No software write path reaches these flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_bus_voltage_floor_q     <=
        RST_IMAGE[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO];
      applied_min_current_threshold_q <=
        RST_IMAGE[`CLB_IMIN_HI:`CLB_IMIN_LO];
      applied_rsvd_q                  <=
        RST_IMAGE[`CLB_RSVD_HI:`CLB_RSVD_LO];
      applied_trip_q                  <= 1'b1;
    end else if (sleep_active) begin
      // Contents fall back to reset values while asleep
      applied_bus_voltage_floor_q     <=
        RST_IMAGE[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO];
      applied_min_current_threshold_q <=
        RST_IMAGE[`CLB_IMIN_HI:`CLB_IMIN_LO];
      applied_rsvd_q                  <=
        RST_IMAGE[`CLB_RSVD_HI:`CLB_RSVD_LO];
      applied_trip_q                  <= 1'b1;
    end else if (emu_done) begin
      applied_bus_voltage_floor_q     <= emu_bus_voltage_floor;
      applied_min_current_threshold_q <=
        emu_min_current_threshold;
      applied_trip_q                  <= emu_trip_sel;
    end
  end

  // ----------------------------------------------------------
  // Custom register: software written, kept through Sleep
  // ----------------------------------------------------------
  // Sleep does not touch these flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      custom_bus_voltage_floor_q     <=
        RST_IMAGE[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO];
      custom_min_current_threshold_q <=
        RST_IMAGE[`CLB_IMIN_HI:`CLB_IMIN_LO];
      custom_rsvd_q                  <=
        RST_IMAGE[`CLB_RSVD_HI:`CLB_RSVD_LO];
    end else if (reg_wr && reg_addr == `CLB_ADDR_CUSTOM) begin
      custom_bus_voltage_floor_q     <=
        reg_wdata[`CLB_VFLOOR_HI:`CLB_VFLOOR_LO];
      custom_min_current_threshold_q <=
        reg_wdata[`CLB_IMIN_HI:`CLB_IMIN_LO];
      // Reserved bits stored as written; software keeps them
      custom_rsvd_q <= reg_wdata[`CLB_RSVD_HI:`CLB_RSVD_LO];
    end
  end

  // ----------------------------------------------------------
  // Emulation outcome capture
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outcome_q <= clb_pkg::CLB_OUT_NONE;
    end else if (sleep_active) begin
      outcome_q <= clb_pkg::CLB_OUT_NONE;
    end else if (emu_done) begin
      outcome_q <= clb_pkg::clb_outcome_t'(emu_outcome);
    end
  end

  // Outcomes that steer to the custom thresholds
  always_comb begin
    case (outcome_q)
      clb_pkg::CLB_OUT_LEGACY_OTHER: use_custom_d = 1'b1;
      clb_pkg::CLB_OUT_CUSTOM:       use_custom_d = 1'b1;
      clb_pkg::CLB_OUT_NO_HANDSHAKE: use_custom_d = 1'b1;
      default:                       use_custom_d = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Feed the decoder with the set in use
  // ----------------------------------------------------------
  always_comb begin
    if (use_custom_d) begin
      link.vfloor_code = custom_bus_voltage_floor_q;
      link.imin_code   = custom_min_current_threshold_q;
    end else begin
      link.vfloor_code = applied_bus_voltage_floor_q;
      link.imin_code   = applied_min_current_threshold_q;
    end
    link.current_limit_setting_ma = current_limit_setting;
  end

  // Mode: custom compare, else the applied choice
  always_comb begin
    trip_d = use_custom_d ? link.trip : applied_trip_q;
  end

  // ----------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      custom_in_use             <= 1'b0;
      trip_limiting             <= 1'b1;
      constant_current_limiting <= 1'b0;
      bus_voltage_floor         <= `CLB_MV_2000;
      min_current_threshold     <= `CLB_MA_100;
    end else begin
      custom_in_use             <= use_custom_d;
      trip_limiting             <= trip_d;
      constant_current_limiting <= ~trip_d;
      bus_voltage_floor         <= link.floor_mv;
      min_current_threshold     <= link.imin_ma;
    end
  end

  // Floor comparison runs in trip and constant-current modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_under_floor <= 1'b0;
    end else begin
      bus_under_floor <= (bus_voltage_mv < link.floor_mv);
    end
  end

  // ----------------------------------------------------------
  // Read data mux; zero for unmapped addresses
  // ----------------------------------------------------------
  always_comb begin
    case (reg_addr)
      `CLB_ADDR_APPLIED: rdata_d = applied_reg;
      `CLB_ADDR_CUSTOM:  rdata_d = custom_reg;
      `CLB_ADDR_PART:    rdata_d = PART_ID;
      `CLB_ADDR_MAKER:   rdata_d = MAKER_ID;
      `CLB_ADDR_REV:     rdata_d = REV_ID;
      default:           rdata_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
